// file: common/rsc_regs.svh
// constants of the ring service channel scheduler
`ifndef RSC_REGS_SVH
`define RSC_REGS_SVH
`define RSC_QDEPTH      5'h10
`define RSC_QAW         4
`define RSC_PH_LAST     3'h4
`define RSC_PH_SVC      3'h2
`define RSC_ELEM_OPDATA 3'h7
`define RSC_HDR_WR_BIT  15
`define RSC_HDR_PROC    11
`define RSC_AT_ERR_BIT  15
`define RSC_PCMD_START  16'h0003
`define RSC_PCMD_CANCEL 16'h0000
`define RSC_PCMD_ACK    5'h07
`define RSC_PCMD_DONE   5'h03
`define RSC_PCMD_ERR    3
`define RSC_IDLE_WORD   16'h0000
`endif

// file: common/rsc_pkg.sv
// types of the ring service channel scheduler
package rsc_pkg;
  typedef struct packed {
    logic [3:0]  slave;
    logic [15:0] idn;
    logic [2:0]  elem;
    logic        write;
    logic        proc;
    logic [15:0] wdata;
  } rsc_req_s;
  typedef enum logic {RSC_SRC_LADDER, RSC_SRC_DIAG} rsc_src_e;
  typedef enum logic [2:0] {S_IDLE, S_LOAD, S_HDR, S_IDN, S_DAT, S_FIN} rsc_state_e;
endpackage : rsc_pkg

// file: common/rsc_qif.sv
// link between scheduler and its request memory
`timescale 1ns/1ps
interface rsc_qif;
  logic                  wr_en;
  logic [3:0]            wr_addr;
  rsc_pkg::rsc_req_s     wr_data;
  logic [3:0]            rd_addr;
  rsc_pkg::rsc_req_s     rd_data;
  modport ctl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface : rsc_qif

// file: logic/rsc_qmem.sv
// request memory of the ladder queue
`timescale 1ns/1ps
module rsc_qmem (
  input wire logic CLK,
  rsc_qif.mem      q
);
  rsc_pkg::rsc_req_s mem_r [16];
  rsc_pkg::rsc_req_s rd_r;
  always_ff @(posedge CLK) begin
    if (q.wr_en) begin
      mem_r[q.wr_addr] <= q.wr_data;
    end
    rd_r <= mem_r[q.rd_addr];
  end
  assign q.rd_data = rd_r;
endmodule : rsc_qmem

// file: logic/rsc_sched.sv
// ring service channel scheduler with cyclic telegram builder
// Operation
// [RL1] one shared service word per telegram
// [RL2] service word always sent, length unchanged
// [RL3] one service word per update each way
// [RL4] requests completed in accepted order; code keeps it within the ladder queue only
// [RL5] one transfer active at a time
// [RL6] ladder queue holds sixteen requests
// [RL7] ladder queue served before diagnostic tool
// [RL8] service transfers only after phase two
// [RL9] any parameter element may be addressed
// [RL10] cyclic data sent every cycle
// [RL11] cyclic data only after phase four
// [RL12] only operation data goes cyclic
// [RL13] each cyclic item takes own words
// [RL14] cyclic layout frozen after phase four
// [RL15] master word in MDT, drive in AT
// [RL16] one channel shared by all slaves
// [RL17] procedure command bits and status codes
// [RL18] phases stepped in order, optional hold
// [RL19] requests record fields, report completion
`timescale 1ns/1ps
`include "rsc_regs.svh"
module rsc_sched (
  input  wire logic        CLK,
  input  wire logic        RESET_N,
  input  wire logic        PHASE_DONE,
  input  wire logic        HOLD_P2,
  input  wire logic        PHASE_CONT,
  output logic [2:0]       PHASE,
  output logic             PHASE_COMPLETE,
  input  wire logic        CYCLE_TICK,
  input  wire logic        LAD_VALID,
  output logic             LAD_READY,
  input  wire logic [3:0]  LAD_SLAVE,
  input  wire logic [15:0] LAD_IDN,
  input  wire logic [2:0]  LAD_ELEM,
  input  wire logic        LAD_WRITE,
  input  wire logic        LAD_PROC,
  input  wire logic [15:0] LAD_WDATA,
  input  wire logic        DIAG_VALID,
  output logic             DIAG_READY,
  input  wire logic [3:0]  DIAG_SLAVE,
  input  wire logic [15:0] DIAG_IDN,
  input  wire logic [2:0]  DIAG_ELEM,
  input  wire logic        DIAG_WRITE,
  input  wire logic        DIAG_PROC,
  input  wire logic [15:0] DIAG_WDATA,
  output logic             BUSY,
  output logic             DONE_VALID,
  output logic             DONE_SRC,
  output logic             DONE_ERR,
  output logic [15:0]      DONE_RDATA,
  input  wire logic        CFG_VALID,
  input  wire logic [2:0]  CFG_COUNT,
  input  wire logic [2:0]  CFG_ELEM,
  output logic             CFG_REFUSED,
  output logic [2:0]       CYC_IDX,
  input  wire logic [15:0] CYC_DATA,
  output logic             MDT_VALID,
  output logic             MDT_LAST,
  output logic [15:0]      MDT_WORD,
  input  wire logic        AT_VALID,
  input  wire logic        AT_FIRST,
  input  wire logic [15:0] AT_WORD
);
  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic rst_a_r;
  logic rst_n;
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_a_r <= 1'b0;
      rst_n   <= 1'b0;
    end else begin
      rst_a_r <= 1'b1;
      rst_n   <= rst_a_r;
    end
  end

  function automatic logic [3:0] ptr_inc(input logic [3:0] p);
    ptr_inc = p + 4'h1;
  endfunction : ptr_inc

  // ----------------------------------------
  // communication phases
  // ----------------------------------------
  logic [2:0] ph_r, ph_nxt;
  logic       phd_r, phd_nxt;
  logic       sc_ok;
  logic       cyc_on;
  always_comb begin
    ph_nxt  = ph_r;
    phd_nxt = phd_r;
    if (!phd_r) begin
      phd_nxt = PHASE_DONE;
    end else if (ph_r != `RSC_PH_LAST) begin
      if (!(ph_r == `RSC_PH_SVC && HOLD_P2) || PHASE_CONT) begin // [RL18]
        ph_nxt  = ph_r + 3'h1;
        phd_nxt = 1'b0;
      end
    end
  end
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      ph_r  <= 3'h0;
      phd_r <= 1'b0;
    end else begin
      ph_r  <= ph_nxt;
      phd_r <= phd_nxt;
    end
  end
  assign sc_ok  = (ph_r > `RSC_PH_SVC) || (ph_r == `RSC_PH_SVC && phd_r); // [RL8]
  assign cyc_on = (ph_r == `RSC_PH_LAST) && phd_r; // [RL11]
  assign PHASE          = ph_r;
  assign PHASE_COMPLETE = phd_r;

  // ----------------------------------------
  // cyclic layout
  // ----------------------------------------
  logic [2:0] cyc_cnt_r, cyc_cnt_nxt;
  logic       cfg_ref_r, cfg_ref_nxt;
  always_comb begin
    cyc_cnt_nxt = cyc_cnt_r;
    cfg_ref_nxt = 1'b0;
    if (CFG_VALID) begin
      if (cyc_on || CFG_ELEM != `RSC_ELEM_OPDATA) begin // [RL14] [RL12]
        cfg_ref_nxt = 1'b1;
      end else begin
        cyc_cnt_nxt = CFG_COUNT;
      end
    end
  end
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      cyc_cnt_r <= 3'h0;
      cfg_ref_r <= 1'b0;
    end else begin
      cyc_cnt_r <= cyc_cnt_nxt;
      cfg_ref_r <= cfg_ref_nxt;
    end
  end
  assign CFG_REFUSED = cfg_ref_r;

  // ----------------------------------------
  // request sources
  // ----------------------------------------
  rsc_qif q ();
  rsc_qmem u_qmem (.CLK(CLK), .q(q));
  logic [3:0] head_r, head_nxt, tail_r, tail_nxt;
  logic [4:0] cnt_r, cnt_nxt;
  logic       push, pop;
  rsc_pkg::rsc_req_s diag_r, diag_nxt;
  logic       diag_v_r, diag_v_nxt;
  rsc_pkg::rsc_state_e st_r, st_nxt;
  rsc_pkg::rsc_src_e   src_r, src_nxt;
  rsc_pkg::rsc_req_s   cur_r, cur_nxt;
  assign LAD_READY  = (cnt_r != `RSC_QDEPTH); // [RL6]
  assign DIAG_READY = !diag_v_r;
  assign push       = LAD_VALID && LAD_READY;
  assign pop        = (st_r == rsc_pkg::S_LOAD) && (src_r == rsc_pkg::RSC_SRC_LADDER);
  assign q.wr_en    = push;
  assign q.wr_addr  = tail_r;
  assign q.wr_data  = '{LAD_SLAVE, LAD_IDN, LAD_ELEM, LAD_WRITE, LAD_PROC, LAD_WDATA}; // [RL19]
  assign q.rd_addr  = head_r;
  always_comb begin
    head_nxt   = pop ? ptr_inc(head_r) : head_r; // [RL4]
    tail_nxt   = push ? ptr_inc(tail_r) : tail_r;
    cnt_nxt    = cnt_r + {4'h0, push} - {4'h0, pop};
    diag_nxt   = diag_r;
    diag_v_nxt = diag_v_r;
    if ((st_r == rsc_pkg::S_LOAD) && (src_r == rsc_pkg::RSC_SRC_DIAG)) begin
      diag_v_nxt = 1'b0;
    end else if (DIAG_VALID && !diag_v_r) begin
      diag_nxt   = '{DIAG_SLAVE, DIAG_IDN, DIAG_ELEM, DIAG_WRITE, DIAG_PROC, DIAG_WDATA};
      diag_v_nxt = 1'b1;
    end
  end
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      head_r   <= 4'h0;
      tail_r   <= 4'h0;
      cnt_r    <= 5'h00;
      diag_r   <= '0;
      diag_v_r <= 1'b0;
    end else begin
      head_r   <= head_nxt;
      tail_r   <= tail_nxt;
      cnt_r    <= cnt_nxt;
      diag_r   <= diag_nxt;
      diag_v_r <= diag_v_nxt;
    end
  end

  // ----------------------------------------
  // transfer sequencer
  // ----------------------------------------
  logic [15:0] svc_word;
  logic        err_r, err_nxt;
  logic [15:0] rdat_r, rdat_nxt;
  logic        done_r, done_nxt;
  logic        at_svc;
  assign at_svc = AT_VALID && AT_FIRST; // [RL15]
  always_comb begin
    case (st_r)
      rsc_pkg::S_HDR: begin // [RL9] [RL16]
        svc_word = {cur_r.write, cur_r.elem, cur_r.proc, 7'h00, cur_r.slave};
      end
      rsc_pkg::S_IDN: svc_word = cur_r.idn;
      rsc_pkg::S_DAT: svc_word = cur_r.write ? cur_r.wdata : `RSC_IDLE_WORD;
      default:        svc_word = `RSC_IDLE_WORD; // [RL2]
    endcase
  end
  always_comb begin
    st_nxt   = st_r;
    src_nxt  = src_r;
    cur_nxt  = cur_r;
    err_nxt  = err_r;
    rdat_nxt = rdat_r;
    done_nxt = 1'b0;
    if (at_svc && st_r != rsc_pkg::S_IDLE && st_r != rsc_pkg::S_LOAD) begin
      rdat_nxt = AT_WORD;
      if (AT_WORD[`RSC_AT_ERR_BIT]) begin
        err_nxt = 1'b1;
      end
    end
    case (st_r)
      rsc_pkg::S_IDLE: begin
        if (sc_ok && cnt_r != 5'h00) begin // [RL7] [RL5]
          src_nxt = rsc_pkg::RSC_SRC_LADDER;
          st_nxt  = rsc_pkg::S_LOAD;
        end else if (sc_ok && diag_v_r) begin
          src_nxt = rsc_pkg::RSC_SRC_DIAG;
          st_nxt  = rsc_pkg::S_LOAD;
        end
      end
      rsc_pkg::S_LOAD: begin
        cur_nxt = (src_r == rsc_pkg::RSC_SRC_LADDER) ? q.rd_data : diag_r;
        err_nxt = 1'b0;
        st_nxt  = rsc_pkg::S_HDR;
      end
      rsc_pkg::S_HDR: if (CYCLE_TICK) st_nxt = rsc_pkg::S_IDN; // [RL3]
      rsc_pkg::S_IDN: if (CYCLE_TICK) st_nxt = rsc_pkg::S_DAT;
      rsc_pkg::S_DAT: if (CYCLE_TICK) st_nxt = rsc_pkg::S_FIN;
      rsc_pkg::S_FIN: begin
        if (CYCLE_TICK) begin
          done_nxt = 1'b1; // [RL19]
          st_nxt   = rsc_pkg::S_IDLE;
          if (cur_r.proc && !cur_r.write && rdat_r[`RSC_PCMD_ERR]) begin // [RL17]
            err_nxt = 1'b1;
          end
        end
      end
      default: st_nxt = rsc_pkg::S_IDLE;
    endcase
  end
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      st_r   <= rsc_pkg::S_IDLE;
      src_r  <= rsc_pkg::RSC_SRC_LADDER;
      cur_r  <= '0;
      err_r  <= 1'b0;
      rdat_r <= 16'h0000;
      done_r <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      src_r  <= src_nxt;
      cur_r  <= cur_nxt;
      err_r  <= err_nxt;
      rdat_r <= rdat_nxt;
      done_r <= done_nxt;
    end
  end
  assign BUSY       = (st_r != rsc_pkg::S_IDLE);
  assign DONE_VALID = done_r;
  assign DONE_SRC   = src_r;
  assign DONE_ERR   = err_r;
  assign DONE_RDATA = rdat_r;

  // ----------------------------------------
  // MDT builder
  // ----------------------------------------
  logic        tx_act_r, tx_act_nxt;
  logic [2:0]  tx_idx_r, tx_idx_nxt;
  logic [2:0]  tx_len_r, tx_len_nxt;
  logic        mv_r, mv_nxt, ml_r, ml_nxt;
  logic [15:0] mw_r, mw_nxt;
  always_comb begin
    tx_act_nxt = tx_act_r;
    tx_idx_nxt = tx_idx_r;
    tx_len_nxt = tx_len_r;
    mv_nxt     = 1'b0;
    ml_nxt     = 1'b0;
    mw_nxt     = mw_r;
    if (CYCLE_TICK) begin
      mv_nxt     = 1'b1;
      mw_nxt     = svc_word; // [RL1] [RL2]
      tx_len_nxt = cyc_on ? cyc_cnt_r : 3'h0; // [RL13] [RL11]
      tx_idx_nxt = 3'h1;
      tx_act_nxt = (tx_len_nxt != 3'h0); // [RL10]
      ml_nxt     = !tx_act_nxt;
    end else if (tx_act_r) begin
      mv_nxt     = 1'b1;
      mw_nxt     = CYC_DATA;
      ml_nxt     = (tx_idx_r == tx_len_r);
      tx_act_nxt = !ml_nxt;
      tx_idx_nxt = tx_idx_r + 3'h1;
    end
  end
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      tx_act_r <= 1'b0;
      tx_idx_r <= 3'h0;
      tx_len_r <= 3'h0;
      mv_r     <= 1'b0;
      ml_r     <= 1'b0;
      mw_r     <= 16'h0000;
    end else begin
      tx_act_r <= tx_act_nxt;
      tx_idx_r <= tx_idx_nxt;
      tx_len_r <= tx_len_nxt;
      mv_r     <= mv_nxt;
      ml_r     <= ml_nxt;
      mw_r     <= mw_nxt;
    end
  end
  assign CYC_IDX   = tx_idx_r - 3'h1;
  assign MDT_VALID = mv_r;
  assign MDT_LAST  = ml_r;
  assign MDT_WORD  = mw_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!rst_n);
  a_svc_present: assert property (CYCLE_TICK |=> MDT_VALID && MDT_WORD == $past(svc_word)) // [RL2]
    else $error("service word missing");
  a_step_one: assert property (st_r == rsc_pkg::S_HDR && CYCLE_TICK |=> st_r == rsc_pkg::S_IDN) // [RL3]
    else $error("service step not one per update");
  a_no_overlap: assert property (st_r inside {rsc_pkg::S_HDR, rsc_pkg::S_IDN, rsc_pkg::S_DAT} |=> st_r != rsc_pkg::S_LOAD) // [RL5]
    else $error("second transfer started");
  a_queue_cap: assert property (cnt_r <= `RSC_QDEPTH && (LAD_READY == (cnt_r != `RSC_QDEPTH))) // [RL6]
    else $error("queue capacity wrong");
  a_ladder_first: assert property (st_r == rsc_pkg::S_IDLE && sc_ok && cnt_r != 5'h00 |=> src_r == rsc_pkg::RSC_SRC_LADDER) // [RL7]
    else $error("diagnostic served before ladder");
  a_sc_phase: assert property (st_r == rsc_pkg::S_IDLE && !sc_ok |=> st_r == rsc_pkg::S_IDLE) // [RL8]
    else $error("service start before phase two");
  a_no_cyc_early: assert property (CYCLE_TICK && !cyc_on |=> MDT_LAST) // [RL11]
    else $error("cyclic words before phase four");
  a_cyc_words: assert property (CYCLE_TICK && cyc_on && cyc_cnt_r == 3'h2 |=> !MDT_LAST ##1 !MDT_LAST ##1 MDT_LAST && MDT_VALID) // [RL13]
    else $error("cyclic word count wrong");
  a_cfg_frozen: assert property (cyc_on && CFG_VALID |=> CFG_REFUSED && $stable(cyc_cnt_r)) // [RL14]
    else $error("layout changed after phase four");
  a_cfg_opdata: assert property (CFG_VALID && CFG_ELEM != `RSC_ELEM_OPDATA |=> CFG_REFUSED) // [RL12]
    else $error("non operation data accepted");
  a_done_pulse: assert property (st_r == rsc_pkg::S_FIN && CYCLE_TICK |=> DONE_VALID ##1 !DONE_VALID) // [RL19]
    else $error("completion pulse wrong");
  a_phase_seq: assert property (!$stable(ph_r) |-> ph_r == $past(ph_r) + 3'h1) // [RL18]
    else $error("phase skipped");
  c_ladder_done: cover property (DONE_VALID && DONE_SRC == rsc_pkg::RSC_SRC_LADDER);
  c_diag_done: cover property (DONE_VALID && DONE_SRC == rsc_pkg::RSC_SRC_DIAG);
  c_queue_full: cover property (cnt_r == `RSC_QDEPTH);
  c_p2_hold: cover property (ph_r == `RSC_PH_SVC && phd_r && HOLD_P2 [*3]);
endmodule : rsc_sched

// file: sim/rsc_drive_model.sv
// drive-side model answering the service word of each telegram
`timescale 1ns/1ps
module rsc_drive_model #(
  parameter logic [15:0] REPLY = 16'h5a3c
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        cycle_tick,
  input  wire logic        mdt_valid,
  input  wire logic        err,
  output logic             at_valid,
  output logic             at_first,
  output logic [15:0]      at_word
);
  logic pend_r;
  // one service word back per telegram, right after the master word
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pend_r   <= 1'b0;
      at_valid <= 1'b0;
      at_first <= 1'b0;
      at_word  <= 16'h0000;
    end else if (pend_r && mdt_valid) begin
      pend_r   <= 1'b0;
      at_valid <= 1'b1;
      at_first <= 1'b1;
      at_word  <= err ? (REPLY | 16'h8000) : REPLY;
    end else begin
      pend_r   <= pend_r | cycle_tick;
      at_valid <= 1'b0;
      at_first <= 1'b0;
      at_word  <= ~at_word;
    end
  end
endmodule : rsc_drive_model

// file: sim/testbench.sv
// self-checking bench of the ring service channel scheduler
`timescale 1ns/1ps
`include "rsc_regs.svh"
module testbench;
  logic        CLK, RESET_N, PHASE_DONE, HOLD_P2, PHASE_CONT, CYCLE_TICK, CFG_VALID;
  logic        LAD_VALID, LAD_READY, LAD_WRITE, LAD_PROC, DIAG_VALID, DIAG_READY;
  logic        DIAG_WRITE, DIAG_PROC, PHASE_COMPLETE, BUSY, DONE_VALID, DONE_SRC;
  logic        DONE_ERR, CFG_REFUSED, MDT_VALID, MDT_LAST, AT_VALID, AT_FIRST, err;
  logic [3:0]  LAD_SLAVE, DIAG_SLAVE;
  logic [2:0]  PHASE, LAD_ELEM, DIAG_ELEM, CFG_COUNT, CFG_ELEM, CYC_IDX;
  logic [15:0] LAD_IDN, LAD_WDATA, DIAG_IDN, DIAG_WDATA, DONE_RDATA, CYC_DATA;
  logic [15:0] MDT_WORD, AT_WORD;
  logic [15:0] svc_q[$], cyc_q[$];
  logic [17:0] done_q[$];
  int          len_q[$];
  int          wcnt = 0;
  int          fails, total_checks;
  logic        first = 1'b0;
  assign CYC_DATA = {13'h1800, CYC_IDX};
  rsc_sched rsc_sched_inst (.*);
  rsc_drive_model rsc_drive_model_inst (.clk(CLK), .reset_n(RESET_N), .cycle_tick(CYCLE_TICK),
    .mdt_valid(MDT_VALID), .err(err), .at_valid(AT_VALID), .at_first(AT_FIRST),
    .at_word(AT_WORD));
  initial begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end
  // ----------------------------------------
  // monitor of telegrams and completions
  // ----------------------------------------
  always @(posedge CLK) begin
    if (CYCLE_TICK) first = 1'b1;
    if (MDT_VALID) begin
      if (first && MDT_WORD !== `RSC_IDLE_WORD) svc_q.push_back(MDT_WORD);
      if (!first) cyc_q.push_back(MDT_WORD);
      first = 1'b0;
      wcnt++;
      if (MDT_LAST) begin
        len_q.push_back(wcnt);
        wcnt = 0;
      end
    end
    if (DONE_VALID) done_q.push_back({DONE_SRC, DONE_ERR, DONE_RDATA});
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge CLK);
    #2;
  endtask : cyc
  task automatic ticks(input int n);
    repeat (n) begin
      CYCLE_TICK = 1'b1;
      cyc(1);
      CYCLE_TICK = 1'b0;
      cyc(9);
    end
  endtask : ticks
  task automatic pulse_done;
    PHASE_DONE = 1'b1;
    cyc(1);
    PHASE_DONE = 1'b0;
    cyc(3);
  endtask : pulse_done
  task automatic cfg(input logic [2:0] n, input logic [2:0] e, input logic exp);
    {CFG_VALID, CFG_COUNT, CFG_ELEM} = {1'b1, n, e};
    cyc(1);
    CFG_VALID = 1'b0;
    chk(16'(CFG_REFUSED), 16'(exp));
    cyc(1);
  endtask : cfg
  function automatic logic [15:0] hdr(input logic [3:0] s, input logic [2:0] e,
                                      input logic w, input logic p);
    return {w, e, p, 7'h00, s};
  endfunction : hdr
  task automatic req(input logic d, input logic [3:0] s, input logic [15:0] idn,
                     input logic [2:0] e, input logic w, input logic p, input logic [15:0] wd);
    int n;
    {LAD_SLAVE, LAD_IDN, LAD_ELEM, LAD_WRITE, LAD_PROC, LAD_WDATA} = {s, idn, e, w, p, wd};
    {DIAG_SLAVE, DIAG_IDN, DIAG_ELEM, DIAG_WRITE, DIAG_PROC, DIAG_WDATA} = {s, idn, e, w, p, wd};
    LAD_VALID = !d;
    DIAG_VALID = d;
    n = 0;
    @(posedge CLK);
    while ((d ? DIAG_READY : LAD_READY) !== 1'b1 && n < 200) begin
      @(posedge CLK);
      n++;
    end
    #2;
    LAD_VALID = 1'b0;
    DIAG_VALID = 1'b0;
    chk(16'(n < 200), 16'h0001);
    cyc(1);
  endtask : req
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_gate;
    chk(16'(PHASE), 16'h0000);
    chk(16'(LAD_READY), 16'h0001);
    req(1'b0, 4'h1, 16'h0101, 3'h7, 1'b1, 1'b1, `RSC_PCMD_START);
    ticks(3);
    chk(16'(BUSY), 16'h0000);
    chk(16'(svc_q.size()), 16'h0000);
    foreach (len_q[i]) chk(16'(len_q[i]), 16'h0001);
  endtask : t_gate
  task automatic t_order;
    logic [3:0] s;
    HOLD_P2 = 1'b1;
    repeat (3) pulse_done;
    chk(16'(PHASE), 16'h0002);
    chk(16'(PHASE_COMPLETE), 16'h0001);
    for (int i = 0; i < 3; i++) begin
      s = (i == 2) ? 4'h9 : 4'(i + 2);
      req(i == 2, s, {4'h0, s, 4'h0, s}, 3'(i + 1), 1'b1, 1'b0, {12'h0a0, s});
    end
    ticks(20);
    chk(16'(done_q.size()), 16'h0004);
    chk(svc_q[0], hdr(4'h1, 3'h7, 1'b1, 1'b1));
    chk(svc_q[2], `RSC_PCMD_START);
    for (int i = 0; i < 3; i++) begin
      s = (i == 2) ? 4'h9 : 4'(i + 2);
      chk(svc_q[3 * i + 3], hdr(s, 3'(i + 1), 1'b1, 1'b0));
      chk(svc_q[3 * i + 4], {4'h0, s, 4'h0, s});
      chk(svc_q[3 * i + 5], {12'h0a0, s});
      chk(16'(done_q[i + 1][17]), 16'(i == 2));
    end
  endtask : t_order
  task automatic t_cfg;
    cfg(3'h2, `RSC_ELEM_OPDATA, 1'b0);
    cfg(3'h2, 3'h3, 1'b1);
    PHASE_CONT = 1'b1;
    cyc(1);
    PHASE_CONT = 1'b0;
    cyc(3);
    chk(16'(PHASE), 16'h0003);
    pulse_done;
    chk(16'(PHASE), 16'h0004);
    len_q.delete();
    ticks(2);
    foreach (len_q[i]) chk(16'(len_q[i]), 16'h0001);
    pulse_done;
    chk(16'(PHASE_COMPLETE), 16'h0001);
  endtask : t_cfg
  task automatic t_cyclic;
    len_q.delete();
    cyc_q.delete();
    ticks(3);
    chk(16'(len_q.size()), 16'h0003);
    foreach (len_q[i]) chk(16'(len_q[i]), 16'h0003);
    chk(cyc_q[0], 16'hc000);
    chk(cyc_q[1], 16'hc001);
    cfg(3'h1, `RSC_ELEM_OPDATA, 1'b1);
    ticks(1);
    chk(16'(len_q[$]), 16'h0003);
  endtask : t_cyclic
  task automatic t_fill;
    svc_q.delete();
    done_q.delete();
    for (int i = 0; i < 17; i++) req(1'b0, 4'(i), 16'h1000 + 16'(i), 3'(i), 1'b1, 1'b0,
                                     16'h2000 + 16'(i));
    chk(16'(LAD_READY), 16'h0000);
    ticks(75);
    chk(16'(done_q.size()), 16'h0011);
    for (int i = 0; i < 17; i++) chk(svc_q[3 * i], hdr(4'(i), 3'(i), 1'b1, 1'b0));
  endtask : t_fill
  task automatic t_read;
    for (int i = 0; i < 3; i++) begin
      done_q.delete();
      err = 1'(i == 1);
      req(1'b0, 4'h5, 16'h0505, 3'h1, 1'b0, 1'(i == 2), 16'h0000);
      ticks(6);
      chk(16'(done_q.size()), 16'h0001);
      chk(16'(done_q[0][16]), 16'(i != 0));
      if (i != 1) chk(done_q[0][15:0], 16'h5a3c);
    end
    err = 1'b0;
  endtask : t_read
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : wrap_up
  initial begin
    #125000;
    fails++;
    wrap_up();
  end
  initial begin
    {PHASE_DONE, HOLD_P2, PHASE_CONT, CYCLE_TICK, CFG_VALID, CFG_COUNT, CFG_ELEM} = '0;
    {LAD_VALID, LAD_SLAVE, LAD_IDN, LAD_ELEM, LAD_WRITE, LAD_PROC, LAD_WDATA} = '0;
    {DIAG_VALID, DIAG_SLAVE, DIAG_IDN, DIAG_ELEM, DIAG_WRITE, DIAG_PROC, DIAG_WDATA} = '0;
    {err, fails, total_checks, RESET_N} = '0;
    repeat (6) @(posedge CLK);
    #2;
    RESET_N = 1'b1;
    cyc(3);
    t_gate();
    t_order();
    t_cfg();
    t_cyclic();
    t_fill();
    t_read();
    wrap_up();
  end
endmodule : testbench
